/* rtl/cid_decoder.sv */
// Instruction decoder: opcode table, operand capture and cycle timing
// What this block does
// - Operation, operand form and length all come from the first opcode byte.
// - Indirect operands use register zero or one; register forms pick one of eight.
// - Multiply and divide are one byte, four cycles; other arithmetic one cycle.
// - Data pointer increment is one byte, two cycles.
// - External data moves are one byte, two cycles, 8-bit or 16-bit address.
// - Code reads add accumulator to program counter or data pointer, two cycles.
// - Add with carry sums accumulator, operand and carry in one cycle.
// - Subtract always deducts operand and borrow; no plain subtract exists.
// - Rotates left and right, plain and through carry, one cycle each.
// - Nibble swap exchanges accumulator halves in one cycle.
// - Low digit exchange swaps only low nibbles with indirect byte.
// - Logic immediate into direct byte: three bytes, two cycles; accumulator forms one.
// - Carry AND/OR with bit or complement: two bytes, two cycles.
// - Bit test and clear branch jumps when set and clears it; three bytes.
// - Compare and branch jumps when unequal; three bytes, two cycles.
// - Decrement and branch jumps when nonzero; two cycles; register form two bytes.
// - Long call and jump carry a full 16-bit destination.
// - Page call and jump replace low 11 bits of next address.
// - Relative jumps add signed offset to the following instruction address.
// - Data pointer load takes its value from bytes two and three.
// - Direct reaches 128 RAM bytes plus registers; bits likewise.
// - Interrupt return is one byte, two cycles, distinct from return.
`timescale 1ns/1ps
`include "cid_regs.svh"
module cid_decoder #(
  parameter int AW = 16
) (
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire logic          clk_en,
  input  wire logic          byte_valid,
  input  wire logic [7:0]    byte_data,
  input  wire logic [AW-1:0] byte_pc,
  output logic               byte_ready,
  output logic               instr_valid,
  input  wire logic          instr_ready,
  output cid_pkg::cid_op_e   instr_op,
  output cid_pkg::cid_am_e   instr_src,
  output cid_pkg::cid_am_e   instr_dst,
  output logic [1:0]         instr_len,
  output logic [2:0]         instr_cycles,
  output logic [2:0]         instr_reg_sel,
  output logic [7:0]         instr_byte2,
  output logic [7:0]         instr_byte3,
  output logic [AW-1:0]      instr_next_pc,
  output logic [AW-1:0]      instr_target,
  output logic               instr_bit_clear,
  output logic               instr_cond_ne,
  output logic               instr_use_carry,
  output logic               instr_low_nibble,
  output logic               instr_direct_sfr,
  output logic               instr_bit_sfr
);
  cid_pkg::cid_st_e  st_q;
  cid_pkg::cid_op_e  op_d, op_q;
  cid_pkg::cid_am_e  src_d, src_q, dst_d, dst_q;
  cid_pkg::cid_tg_e  tg_d, tg_q;
  logic [1:0]        len_d, len_q, cnt_q;
  logic [2:0]        cyc_d, cyc_q, wait_q;
  logic [7:0]        opc_q, b2_q, b3_q;
  logic [AW-1:0]     pc_q;
  logic [AW-1:0]     target;
  logic [3:0]        row;
  logic [3:0]        col;
  logic              take_op;
  logic              take_oper;

  assign row = byte_data[7:`CID_ROW_LSB];
  assign col = byte_data[3:`CID_COL_LSB];

  // Pure table lookup from the first byte only
  always_comb begin
    op_d  = cid_pkg::CID_OP_UNDEF;
    src_d = cid_pkg::CID_AM_NONE;
    dst_d = cid_pkg::CID_AM_NONE;
    tg_d  = cid_pkg::CID_TG_NONE;
    len_d = `CID_LEN_ONE;
    cyc_d = `CID_CYC_ONE;
    if (col >= 4'h8) begin
      src_d = cid_pkg::CID_AM_REG;
    end else if (col == 4'h6 || col == 4'h7) begin
      src_d = cid_pkg::CID_AM_INDIRECT;
    end else if (col == 4'h5) begin
      src_d = cid_pkg::CID_AM_DIRECT;
      len_d = `CID_LEN_TWO;
    end else if (col == 4'h4) begin
      src_d = cid_pkg::CID_AM_IMM;
      len_d = `CID_LEN_TWO;
    end
    if (col >= 4'h4) begin
      unique case (row)
        4'h0: op_d = cid_pkg::CID_OP_INC;
        4'h1: op_d = cid_pkg::CID_OP_DEC;
        4'h2: op_d = cid_pkg::CID_OP_ADD;
        4'h3: op_d = cid_pkg::CID_OP_ADD_WITH_CARRY_OP;
        4'h4: op_d = cid_pkg::CID_OP_OR;
        4'h5: op_d = cid_pkg::CID_OP_AND;
        4'h6: op_d = cid_pkg::CID_OP_XOR;
        4'h7: op_d = cid_pkg::CID_OP_MOV;
        4'h8: op_d = cid_pkg::CID_OP_MOV;
        4'h9: op_d = cid_pkg::CID_OP_SUBTRACT_BORROW_OP;
        4'hA: op_d = cid_pkg::CID_OP_MOV;
        4'hB: op_d = cid_pkg::CID_OP_CMP_BR;
        4'hC: op_d = cid_pkg::CID_OP_XCH;
        4'hD: op_d = cid_pkg::CID_OP_DEC_BR;
        4'hE: op_d = cid_pkg::CID_OP_MOV;
        4'hF: op_d = cid_pkg::CID_OP_MOV;
      endcase
      dst_d = cid_pkg::CID_AM_ACC;
      if (row <= 4'h1) begin
        dst_d = src_d;
        src_d = cid_pkg::CID_AM_NONE;
        if (col == 4'h4) begin
          op_d  = row[0] ? cid_pkg::CID_OP_DEC : cid_pkg::CID_OP_INC;
          dst_d = cid_pkg::CID_AM_ACC;
          len_d = `CID_LEN_ONE;
        end
      end else if (row == 4'h7) begin
        dst_d = (col == 4'h5) ? cid_pkg::CID_AM_DIRECT : ((col == 4'h4) ? cid_pkg::CID_AM_ACC : src_d);
        src_d = cid_pkg::CID_AM_IMM;
        len_d = (col == 4'h5) ? `CID_LEN_THREE : `CID_LEN_TWO;
        cyc_d = (col == 4'h5) ? `CID_CYC_TWO : `CID_CYC_ONE;
      end else if (row == 4'h8) begin
        dst_d = cid_pkg::CID_AM_DIRECT;
        len_d = (col == 4'h5) ? `CID_LEN_THREE : `CID_LEN_TWO;
        cyc_d = `CID_CYC_TWO;
      end else if (row == 4'hA) begin
        dst_d = src_d;
        src_d = cid_pkg::CID_AM_DIRECT;
        len_d = `CID_LEN_TWO;
        cyc_d = `CID_CYC_TWO;
      end else if (row == 4'hB) begin
        dst_d = (col <= 4'h5) ? cid_pkg::CID_AM_ACC : src_d;
        src_d = (col == 4'h5) ? cid_pkg::CID_AM_DIRECT : cid_pkg::CID_AM_IMM;
        len_d = `CID_LEN_THREE;
        cyc_d = `CID_CYC_TWO;
        tg_d  = cid_pkg::CID_TG_REL;
      end else if (row == 4'hD) begin
        dst_d = src_d;
        src_d = cid_pkg::CID_AM_NONE;
        len_d = (col == 4'h5) ? `CID_LEN_THREE : `CID_LEN_TWO;
        cyc_d = `CID_CYC_TWO;
        tg_d  = cid_pkg::CID_TG_REL;
        if (col == 4'h6 || col == 4'h7) begin
          op_d  = cid_pkg::CID_OP_LOW_DIGIT_EXCHANGE_OP;
          dst_d = cid_pkg::CID_AM_ACC;
          src_d = cid_pkg::CID_AM_INDIRECT;
          len_d = `CID_LEN_ONE;
          cyc_d = `CID_CYC_ONE;
          tg_d  = cid_pkg::CID_TG_NONE;
        end else if (col == 4'h4) begin
          op_d  = cid_pkg::CID_OP_DA;
          dst_d = cid_pkg::CID_AM_ACC;
          len_d = `CID_LEN_ONE;
          cyc_d = `CID_CYC_ONE;
          tg_d  = cid_pkg::CID_TG_NONE;
        end
      end else if (row == 4'hF) begin
        dst_d = src_d;
        src_d = cid_pkg::CID_AM_ACC;
        if (col == 4'h4) begin
          op_d  = cid_pkg::CID_OP_CPL;
          dst_d = cid_pkg::CID_AM_ACC;
          src_d = cid_pkg::CID_AM_NONE;
          len_d = `CID_LEN_ONE;
        end
      end else if (row == 4'hE && col == 4'h4) begin
        op_d  = cid_pkg::CID_OP_CLR;
        src_d = cid_pkg::CID_AM_NONE;
        len_d = `CID_LEN_ONE;
      end else if (row == 4'hC && col == 4'h4) begin
        op_d  = cid_pkg::CID_OP_SWAP;
        src_d = cid_pkg::CID_AM_NONE;
        len_d = `CID_LEN_ONE;
      end else if (row == 4'h8 || row == 4'h9) begin
        dst_d = cid_pkg::CID_AM_ACC;
      end
      if (row == 4'hA && col == 4'h5) begin
        op_d  = cid_pkg::CID_OP_UNDEF;
        src_d = cid_pkg::CID_AM_NONE;
        dst_d = cid_pkg::CID_AM_NONE;
        len_d = `CID_LEN_ONE;
        cyc_d = `CID_CYC_ONE;
      end
      if (row == 4'h8 && col == 4'h4) begin
        op_d = cid_pkg::CID_OP_DIV;
        src_d = cid_pkg::CID_AM_NONE;
        len_d = `CID_LEN_ONE;
        cyc_d = `CID_CYC_FOUR;
      end else if (row == 4'hA && col == 4'h4) begin
        op_d = cid_pkg::CID_OP_MUL;
        src_d = cid_pkg::CID_AM_NONE;
        len_d = `CID_LEN_ONE;
        cyc_d = `CID_CYC_FOUR;
      end
    end else if (col == 4'h1) begin
      op_d  = byte_data[4] ? cid_pkg::CID_OP_CALL_PAGE : cid_pkg::CID_OP_JMP_PAGE;
      len_d = `CID_LEN_TWO;
      cyc_d = `CID_CYC_TWO;
      tg_d  = cid_pkg::CID_TG_PAGE;
    end else begin
      unique case (byte_data[7:0])
        8'h00: op_d = cid_pkg::CID_OP_NOP;
        8'h02, 8'h12: begin
          op_d = (row == 4'h1) ? cid_pkg::CID_OP_CALL_LONG : cid_pkg::CID_OP_JMP_LONG;
          len_d = `CID_LEN_THREE; cyc_d = `CID_CYC_TWO; tg_d = cid_pkg::CID_TG_LONG;
        end
        8'h03: op_d = cid_pkg::CID_OP_RR;
        8'h13: op_d = cid_pkg::CID_OP_RRC;
        8'h23: op_d = cid_pkg::CID_OP_RL;
        8'h33: op_d = cid_pkg::CID_OP_RLC;
        8'h10, 8'h20, 8'h30: begin
          op_d = (row == 4'h1) ? cid_pkg::CID_OP_JBC : ((row == 4'h2) ? cid_pkg::CID_OP_JB : cid_pkg::CID_OP_JNB);
          src_d = cid_pkg::CID_AM_BIT; len_d = `CID_LEN_THREE;
          cyc_d = `CID_CYC_TWO; tg_d = cid_pkg::CID_TG_REL;
        end
        8'h22: begin op_d = cid_pkg::CID_OP_RET; cyc_d = `CID_CYC_TWO; end
        8'h32: begin op_d = cid_pkg::CID_OP_INTERRUPT_RETURN_OP; cyc_d = `CID_CYC_TWO; end
        8'h40, 8'h50, 8'h60, 8'h70, 8'h80: begin
          unique case (row)
            4'h4: op_d = cid_pkg::CID_OP_JC;
            4'h5: op_d = cid_pkg::CID_OP_JNC;
            4'h6: op_d = cid_pkg::CID_OP_JZ;
            4'h7: op_d = cid_pkg::CID_OP_JNZ;
            default: op_d = cid_pkg::CID_OP_JMP_SHORT;
          endcase
          len_d = `CID_LEN_TWO; cyc_d = `CID_CYC_TWO; tg_d = cid_pkg::CID_TG_REL;
        end
        8'h42, 8'h52, 8'h62: begin
          op_d = (row == 4'h4) ? cid_pkg::CID_OP_OR : ((row == 4'h5) ? cid_pkg::CID_OP_AND : cid_pkg::CID_OP_XOR);
          src_d = cid_pkg::CID_AM_ACC; dst_d = cid_pkg::CID_AM_DIRECT; len_d = `CID_LEN_TWO;
        end
        8'h43, 8'h53, 8'h63: begin
          op_d = (row == 4'h4) ? cid_pkg::CID_OP_OR : ((row == 4'h5) ? cid_pkg::CID_OP_AND : cid_pkg::CID_OP_XOR);
          src_d = cid_pkg::CID_AM_IMM; dst_d = cid_pkg::CID_AM_DIRECT;
          len_d = `CID_LEN_THREE; cyc_d = `CID_CYC_TWO;
        end
        8'h72, 8'h82, 8'hA0, 8'hB0: begin
          op_d = (row == 4'h7 || row == 4'hA) ? cid_pkg::CID_OP_OR : cid_pkg::CID_OP_AND;
          src_d = (row >= 4'hA) ? cid_pkg::CID_AM_NBIT : cid_pkg::CID_AM_BIT;
          dst_d = cid_pkg::CID_AM_CARRY; len_d = `CID_LEN_TWO; cyc_d = `CID_CYC_TWO;
        end
        8'h73: begin op_d = cid_pkg::CID_OP_JMP_IND; cyc_d = `CID_CYC_TWO; tg_d = cid_pkg::CID_TG_IND; end
        8'h83, 8'h93: begin
          op_d = cid_pkg::CID_OP_CODE_RD; dst_d = cid_pkg::CID_AM_ACC; cyc_d = `CID_CYC_TWO;
          src_d = (row == 4'h8) ? cid_pkg::CID_AM_CODE_PC : cid_pkg::CID_AM_CODE_DP;
        end
        8'h90: begin
          op_d = cid_pkg::CID_OP_MOV_DP; src_d = cid_pkg::CID_AM_IMM16;
          len_d = `CID_LEN_THREE; cyc_d = `CID_CYC_TWO;
        end
        8'h92, 8'hA2: begin
          op_d = cid_pkg::CID_OP_MOV; len_d = `CID_LEN_TWO;
          src_d = (row == 4'h9) ? cid_pkg::CID_AM_CARRY : cid_pkg::CID_AM_BIT;
          dst_d = (row == 4'h9) ? cid_pkg::CID_AM_BIT : cid_pkg::CID_AM_CARRY;
          cyc_d = (row == 4'h9) ? `CID_CYC_TWO : `CID_CYC_ONE;
        end
        8'hA3: begin op_d = cid_pkg::CID_OP_INC_DP; cyc_d = `CID_CYC_TWO; end
        8'hB2, 8'hC2, 8'hD2: begin
          op_d = (row == 4'hB) ? cid_pkg::CID_OP_CPL : ((row == 4'hC) ? cid_pkg::CID_OP_CLR : cid_pkg::CID_OP_SETB);
          dst_d = cid_pkg::CID_AM_BIT; len_d = `CID_LEN_TWO;
        end
        8'hB3, 8'hC3, 8'hD3: begin
          op_d = (row == 4'hB) ? cid_pkg::CID_OP_CPL : ((row == 4'hC) ? cid_pkg::CID_OP_CLR : cid_pkg::CID_OP_SETB);
          dst_d = cid_pkg::CID_AM_CARRY;
        end
        8'hC0, 8'hD0: begin
          op_d = (row == 4'hC) ? cid_pkg::CID_OP_PUSH : cid_pkg::CID_OP_POP;
          src_d = cid_pkg::CID_AM_DIRECT; len_d = `CID_LEN_TWO; cyc_d = `CID_CYC_TWO;
        end
        8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3: begin
          op_d = (row == 4'hE) ? cid_pkg::CID_OP_EXT_RD : cid_pkg::CID_OP_EXT_WR; cyc_d = `CID_CYC_TWO;
          src_d = (col == 4'h0) ? cid_pkg::CID_AM_EXT16 : cid_pkg::CID_AM_EXT8;
          dst_d = cid_pkg::CID_AM_ACC;
        end
        default: op_d = cid_pkg::CID_OP_UNDEF;
      endcase
    end
  end

  assign take_op   = clk_en && byte_valid && byte_ready && st_q == cid_pkg::CID_ST_IDLE;
  assign take_oper = clk_en && byte_valid && byte_ready && st_q == cid_pkg::CID_ST_OPER;
  assign byte_ready = (st_q != cid_pkg::CID_ST_EXEC);

  // Fetch and hold sequencer; execution held for the cycle count
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_q   <= cid_pkg::CID_ST_IDLE;
      cnt_q  <= 2'h0;
      wait_q <= 3'h0;
    end else if (clk_en) begin
      unique case (st_q)
        cid_pkg::CID_ST_IDLE: if (take_op) begin
          cnt_q  <= 2'h1;
          wait_q <= cyc_d;
          st_q   <= (len_d == `CID_LEN_ONE) ? cid_pkg::CID_ST_EXEC : cid_pkg::CID_ST_OPER;
        end
        cid_pkg::CID_ST_OPER: if (take_oper) begin
          cnt_q <= cnt_q + 2'h1;
          if (cnt_q + 2'h1 == len_q) st_q <= cid_pkg::CID_ST_EXEC;
        end
        cid_pkg::CID_ST_EXEC: begin
          if (wait_q > 3'h1) wait_q <= wait_q - 3'h1;
          else if (instr_ready) st_q <= cid_pkg::CID_ST_IDLE;
        end
      endcase
    end
  end

  // Instruction fields captured with the opcode and operand bytes
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      op_q <= cid_pkg::CID_OP_NOP; src_q <= cid_pkg::CID_AM_NONE; dst_q <= cid_pkg::CID_AM_NONE;
      tg_q <= cid_pkg::CID_TG_NONE; len_q <= `CID_LEN_RESET; cyc_q <= `CID_CYC_RESET;
      opc_q <= 8'h00; b2_q <= 8'h00; b3_q <= 8'h00; pc_q <= '0;
    end else if (take_op) begin
      op_q <= op_d; src_q <= src_d; dst_q <= dst_d; tg_q <= tg_d;
      len_q <= len_d; cyc_q <= cyc_d; opc_q <= byte_data;
      b2_q <= 8'h00; b3_q <= 8'h00;
      pc_q <= AW'(byte_pc + AW'(len_d));
    end else if (take_oper) begin
      if (cnt_q == 2'h1) b2_q <= byte_data;
      else b3_q <= byte_data;
    end
  end

  cid_target #(.AW(AW)) u_target (
    .next_pc (pc_q),
    .opcode  (opc_q),
    .byte2   (b2_q),
    .byte3   (b3_q),
    .rel     ((len_q == `CID_LEN_THREE) ? b3_q : b2_q),
    .kind    (tg_q),
    .target  (target)
  );

  assign instr_valid      = (st_q == cid_pkg::CID_ST_EXEC) && wait_q <= 3'h1;
  assign instr_op         = op_q;
  assign instr_src        = src_q;
  assign instr_dst        = dst_q;
  assign instr_len        = len_q;
  assign instr_cycles     = cyc_q;
  assign instr_reg_sel    = opc_q[3] ? opc_q[2:0] : {2'h0, opc_q[`CID_IND_SEL_BIT]};
  assign instr_byte2      = b2_q;
  assign instr_byte3      = b3_q;
  assign instr_next_pc    = pc_q;
  assign instr_target     = target;
  assign instr_bit_clear  = (op_q == cid_pkg::CID_OP_JBC);
  assign instr_cond_ne    = (op_q == cid_pkg::CID_OP_CMP_BR) || (op_q == cid_pkg::CID_OP_DEC_BR);
  assign instr_use_carry  = (op_q == cid_pkg::CID_OP_ADD_WITH_CARRY_OP) || (op_q == cid_pkg::CID_OP_SUBTRACT_BORROW_OP);
  assign instr_low_nibble = (op_q == cid_pkg::CID_OP_LOW_DIGIT_EXCHANGE_OP);
  assign instr_direct_sfr = b2_q > `CID_DIRECT_RAM_TOP;
  assign instr_bit_sfr    = b2_q[7];

  muldiv_len_a: assert property (@(posedge clk) disable iff (!reset_n)
    take_op && (byte_data == 8'hA4 || byte_data == 8'h84) |=> len_q == 2'h1 && cyc_q == 3'h4)
    else $error("multiply or divide timing wrong");
  incdp_time_a: assert property (@(posedge clk) disable iff (!reset_n)
    take_op && byte_data == 8'hA3 |=> op_q == cid_pkg::CID_OP_INC_DP && cyc_q == 3'h2 && len_q == 2'h1)
    else $error("pointer increment timing wrong");
  ext_move_a: assert property (@(posedge clk) disable iff (!reset_n)
    take_op && byte_data[7:5] == 3'h7 && byte_data[3:0] != 4'h1 && byte_data[3:2] == 2'h0 && byte_data[1:0] != 2'h1
    |=> cyc_q == 3'h2 && len_q == 2'h1)
    else $error("external move timing wrong");
  logic_imm_a: assert property (@(posedge clk) disable iff (!reset_n)
    take_op && (byte_data == 8'h43 || byte_data == 8'h53 || byte_data == 8'h63) |=> len_q == 2'h3 && cyc_q == 3'h2)
    else $error("logic immediate direct timing wrong");
  cmp_branch_a: assert property (@(posedge clk) disable iff (!reset_n)
    take_op && byte_data[7:4] == 4'hB && byte_data[3:2] != 2'h0 |=> len_q == 2'h3 && instr_cond_ne)
    else $error("compare branch decode wrong");
  undef_op_a: assert property (@(posedge clk) disable iff (!reset_n)
    take_op && byte_data == 8'hA5 |=> len_q == 2'h1 && cyc_q == 3'h1 && st_q == cid_pkg::CID_ST_EXEC)
    else $error("undefined opcode not a one byte no-op");
  interrupt_return_op_time_a: assert property (@(posedge clk) disable iff (!reset_n)
    take_op && byte_data == 8'h32 |=> op_q == cid_pkg::CID_OP_INTERRUPT_RETURN_OP && cyc_q == 3'h2)
    else $error("interrupt return decode wrong");
  hold_exec_a: assert property (@(posedge clk) disable iff (!reset_n)
    take_op && clk_en && byte_data == 8'hA4 |=> !instr_valid [*3])
    else $error("multiply released early");
endmodule

/* rtl/cid_regs.svh */
// Constants for the instruction decoder: field positions, reset values, cycle counts
`ifndef CID_REGS_SVH
`define CID_REGS_SVH
`define CID_LEN_RESET     2'h1
`define CID_CYC_RESET     3'h1
`define CID_CYC_ONE       3'h1
`define CID_CYC_TWO       3'h2
`define CID_CYC_FOUR      3'h4
`define CID_LEN_ONE       2'h1
`define CID_LEN_TWO       2'h2
`define CID_LEN_THREE     2'h3
`define CID_PAGE_BITS     11
`define CID_REG_SEL_LSB   0
`define CID_IND_SEL_BIT   0
`define CID_ROW_LSB       4
`define CID_COL_LSB       0
`define CID_DIRECT_RAM_TOP 8'h7F
`endif

/* rtl/cid_pkg.sv */
// Types shared by the instruction decoder files
package cid_pkg;
  typedef enum logic [5:0] {
    CID_OP_NOP, CID_OP_ADD, CID_OP_ADD_WITH_CARRY_OP, CID_OP_SUBTRACT_BORROW_OP, CID_OP_INC, CID_OP_DEC,
    CID_OP_INC_DP, CID_OP_MUL, CID_OP_DIV, CID_OP_DA, CID_OP_AND, CID_OP_OR, CID_OP_XOR,
    CID_OP_CLR, CID_OP_CPL, CID_OP_RL, CID_OP_RLC, CID_OP_RR, CID_OP_RRC, CID_OP_SWAP,
    CID_OP_MOV, CID_OP_MOV_DP, CID_OP_CODE_RD, CID_OP_EXT_RD, CID_OP_EXT_WR,
    CID_OP_PUSH, CID_OP_POP, CID_OP_XCH, CID_OP_LOW_DIGIT_EXCHANGE_OP, CID_OP_SETB,
    CID_OP_CALL_PAGE, CID_OP_CALL_LONG, CID_OP_RET, CID_OP_INTERRUPT_RETURN_OP,
    CID_OP_JMP_PAGE, CID_OP_JMP_LONG, CID_OP_JMP_SHORT, CID_OP_JMP_IND,
    CID_OP_JZ, CID_OP_JNZ, CID_OP_JC, CID_OP_JNC, CID_OP_JB, CID_OP_JNB, CID_OP_JBC,
    CID_OP_CMP_BR, CID_OP_DEC_BR, CID_OP_UNDEF
  } cid_op_e;
  typedef enum logic [3:0] {
    CID_AM_NONE, CID_AM_REG, CID_AM_DIRECT, CID_AM_INDIRECT, CID_AM_IMM, CID_AM_IMM16,
    CID_AM_BIT, CID_AM_NBIT, CID_AM_CARRY, CID_AM_EXT8, CID_AM_EXT16, CID_AM_CODE_PC,
    CID_AM_CODE_DP, CID_AM_ACC
  } cid_am_e;
  typedef enum logic [2:0] {
    CID_TG_NONE, CID_TG_PAGE, CID_TG_LONG, CID_TG_REL, CID_TG_IND
  } cid_tg_e;
  typedef enum {
    CID_ST_IDLE, CID_ST_OPER, CID_ST_EXEC
  } cid_st_e;
endpackage

/* rtl/cid_target.sv */
// Branch target arithmetic for page, long and relative destinations
`timescale 1ns/1ps
`include "cid_regs.svh"
module cid_target #(
  parameter int AW = 16
) (
  input  wire logic [AW-1:0]  next_pc,
  input  wire logic [7:0]     opcode,
  input  wire logic [7:0]     byte2,
  input  wire logic [7:0]     byte3,
  input  wire logic [7:0]     rel,
  input  wire cid_pkg::cid_tg_e kind,
  output logic      [AW-1:0]  target
);
  logic [AW-1:0] rel_ext;
  always_comb begin
    rel_ext = {{(AW-8){rel[7]}}, rel};
    unique case (kind)
      // Upper page bits kept from the following instruction
      cid_pkg::CID_TG_PAGE: target = {next_pc[AW-1:`CID_PAGE_BITS], opcode[7:5], byte2};
      cid_pkg::CID_TG_LONG: target = AW'({byte2, byte3});
      cid_pkg::CID_TG_REL:  target = AW'(next_pc + rel_ext);
      default:              target = next_pc;
    endcase
  end
endmodule

/* tb/cid_decoder_tb.sv */
// Self-checking bench for the instruction decoder
`timescale 1ns/1ps
module cid_decoder_tb;
  logic             clk = 1'b0;
  logic             reset_n = 1'b0;
  logic             clk_en = 1'b1;
  logic             byte_valid = 1'b0;
  logic [7:0]       byte_data = 8'h00;
  logic [15:0]      byte_pc = 16'h0000;
  logic             instr_ready = 1'b1;
  logic             byte_ready, instr_valid, instr_bit_clear, instr_cond_ne, instr_use_carry;
  logic             instr_low_nibble, instr_direct_sfr, instr_bit_sfr;
  cid_pkg::cid_op_e instr_op;
  cid_pkg::cid_am_e instr_src, instr_dst;
  logic [1:0]       instr_len;
  logic [2:0]       instr_cycles, instr_reg_sel;
  logic [7:0]       instr_byte2, instr_byte3;
  logic [15:0]      instr_next_pc, instr_target;
  int               bad_count = 0;
  int               n_checks = 0;
  int               waits;
  // Entry: opcode, length, cycles
  logic [15:0]      tab [39] = '{16'h0011, 16'h2521, 16'h3521, 16'h9421, 16'hA312, 16'hA414, 16'h8414, 16'hE012,
    16'hE212, 16'hF012, 16'hF212, 16'h9312, 16'h8312, 16'h3311, 16'h1311, 16'h2311, 16'h0311, 16'hC411, 16'hD611,
    16'h5332, 16'h4332, 16'h6332, 16'h5421, 16'h8222, 16'hA022, 16'h1032, 16'hB432, 16'hD822, 16'hD532, 16'h3212,
    16'h2212, 16'hA511, 16'h0232, 16'h1232, 16'hE122, 16'h9032, 16'h7532, 16'hE411, 16'hF411};
  cid_pkg::cid_op_e tab_op [39] = '{cid_pkg::CID_OP_NOP, cid_pkg::CID_OP_ADD, cid_pkg::CID_OP_ADD_WITH_CARRY_OP,
    cid_pkg::CID_OP_SUBTRACT_BORROW_OP, cid_pkg::CID_OP_INC_DP, cid_pkg::CID_OP_MUL, cid_pkg::CID_OP_DIV, cid_pkg::CID_OP_EXT_RD,
    cid_pkg::CID_OP_EXT_RD, cid_pkg::CID_OP_EXT_WR, cid_pkg::CID_OP_EXT_WR, cid_pkg::CID_OP_CODE_RD,
    cid_pkg::CID_OP_CODE_RD, cid_pkg::CID_OP_RLC, cid_pkg::CID_OP_RRC, cid_pkg::CID_OP_RL, cid_pkg::CID_OP_RR,
    cid_pkg::CID_OP_SWAP, cid_pkg::CID_OP_LOW_DIGIT_EXCHANGE_OP, cid_pkg::CID_OP_AND, cid_pkg::CID_OP_OR, cid_pkg::CID_OP_XOR,
    cid_pkg::CID_OP_AND, cid_pkg::CID_OP_AND, cid_pkg::CID_OP_OR, cid_pkg::CID_OP_JBC, cid_pkg::CID_OP_CMP_BR,
    cid_pkg::CID_OP_DEC_BR, cid_pkg::CID_OP_DEC_BR, cid_pkg::CID_OP_INTERRUPT_RETURN_OP, cid_pkg::CID_OP_RET,
    cid_pkg::CID_OP_UNDEF, cid_pkg::CID_OP_JMP_LONG, cid_pkg::CID_OP_CALL_LONG, cid_pkg::CID_OP_JMP_PAGE,
    cid_pkg::CID_OP_MOV_DP, cid_pkg::CID_OP_MOV, cid_pkg::CID_OP_CLR, cid_pkg::CID_OP_CPL};
  // Entry: opcode, length, flags carry/low nibble/bit clear/not equal
  logic [15:0]      ftab [8] = '{16'h3528, 16'h2520, 16'h9428, 16'hD614, 16'hC610, 16'h1032, 16'h2030, 16'hB431};

  cid_decoder #(.AW(16)) dut (.clk, .reset_n, .clk_en, .byte_valid, .byte_data, .byte_pc, .byte_ready,
    .instr_valid, .instr_ready, .instr_op, .instr_src, .instr_dst, .instr_len, .instr_cycles, .instr_reg_sel,
    .instr_byte2, .instr_byte3, .instr_next_pc, .instr_target, .instr_bit_clear, .instr_cond_ne,
    .instr_use_carry, .instr_low_nibble, .instr_direct_sfr, .instr_bit_sfr);

  always #5 clk = ~clk;

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Whole instruction sent back to back; counts extra edges until offered
  task automatic run(input logic [7:0] op, input logic [7:0] b2, input logic [7:0] b3, input logic [15:0] pc,
                     input int len);
    @(posedge clk);
    byte_valid <= 1'b1;
    byte_data  <= op;
    byte_pc    <= pc;
    for (int i = 2; i <= len; i++) begin
      @(posedge clk);
      byte_data <= (i == 2) ? b2 : b3;
    end
    @(posedge clk);
    byte_valid <= 1'b0;
    #1;
    waits = 0;
    while (instr_valid !== 1'b1 && waits < 20) begin
      @(posedge clk);
      #1;
      waits++;
    end
    chk("instr_valid", instr_valid, 1'b1);
  endtask

  // Also releases a stalled consumer, so a mid-run reset is covered
  task automatic t_reset();
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (5) @(posedge clk);
    reset_n     <= 1'b1;
    instr_ready <= 1'b1;
    #1;
    chk("rst valid", instr_valid, 1'b0);
    chk("rst ready", byte_ready, 1'b1);
    chk("rst len", {instr_len, instr_cycles}, {2'h1, 3'h1});
  endtask

  task automatic t_table();
    for (int k = 0; k < 39; k++) begin
      run(tab[k][15:8], 8'h5A, 8'hC3, 16'h0400, int'(tab[k][7:4]));
      chk("op", instr_op, tab_op[k]);
      chk("len", instr_len, tab[k][7:4]);
      chk("cycles", instr_cycles, tab[k][3:0]);
      chk("hold", waits, tab[k][3:0] - 1);
      chk("byte2", instr_byte2, tab[k][7:4] > 1 ? 8'h5A : 8'h00);
      chk("byte3", instr_byte3, tab[k][7:4] > 2 ? 8'hC3 : 8'h00);
      chk("next_pc", instr_next_pc, 16'h0400 + tab[k][7:4]);
    end
    for (int k = 0; k < 8; k++) begin
      run(ftab[k][15:8], 8'h20, 8'h10, 16'h0000, int'(ftab[k][7:4]));
      chk("flags", {instr_use_carry, instr_low_nibble, instr_bit_clear, instr_cond_ne}, ftab[k][3:0]);
    end
  endtask

  task automatic t_targets();
    run(8'h02, 8'hAB, 8'hCD, 16'h1230, 3);
    chk("long jump", instr_target, 16'hABCD);
    run(8'h12, 8'hFF, 8'hFF, 16'h0010, 3);
    chk("long call", instr_target, 16'hFFFF);
    run(8'hE1, 8'h45, 8'h00, 16'h37FE, 2);
    chk("page", instr_target, 16'h3F45);
    run(8'h80, 8'hFE, 8'h00, 16'h0100, 2);
    chk("rel back", instr_target, 16'h0100);
    run(8'h80, 8'h7F, 8'h00, 16'h0100, 2);
    chk("rel fwd", instr_target, 16'h0181);
    run(8'hB4, 8'h55, 8'h80, 16'h2000, 3);
    chk("cmp rel", instr_target, 16'h1F83);
    run(8'h90, 8'h12, 8'h34, 16'h0000, 3);
    chk("dp const", {instr_byte2, instr_byte3}, 16'h1234);
  endtask

  task automatic t_operands();
    run(8'h0E, 8'h00, 8'h00, 16'h0000, 1);
    chk("reg sel", instr_reg_sel, 3'h6);
    chk("reg dst", instr_dst, cid_pkg::CID_AM_REG);
    run(8'h17, 8'h00, 8'h00, 16'h0000, 1);
    chk("ind sel", instr_reg_sel, 3'h1);
    chk("ind dst", instr_dst, cid_pkg::CID_AM_INDIRECT);
    run(8'h74, 8'h33, 8'h00, 16'h0000, 2);
    chk("imm form", {instr_src, instr_dst}, {cid_pkg::CID_AM_IMM, cid_pkg::CID_AM_ACC});
    for (int k = 0; k < 2; k++) begin
      run(8'h25, k ? 8'h80 : 8'h7F, 8'h00, 16'h0000, 2);
      chk("direct sfr", instr_direct_sfr, k);
      chk("direct src", instr_src, cid_pkg::CID_AM_DIRECT);
      run(8'hD2, k ? 8'h80 : 8'h7F, 8'h00, 16'h0000, 2);
      chk("bit sfr", instr_bit_sfr, k);
    end
  endtask

  // Stalled consumer plus frozen clock; a byte offered meanwhile is dropped
  task automatic t_stall();
    @(posedge clk);
    instr_ready <= 1'b0;
    run(8'hA4, 8'h00, 8'h00, 16'h0050, 1);
    @(posedge clk);
    byte_valid <= 1'b1;
    byte_data  <= 8'h04;
    repeat (4) begin
      @(posedge clk);
      #1;
      chk("stall op", instr_op, cid_pkg::CID_OP_MUL);
      chk("stall refuse", {instr_valid, byte_ready}, 2'h2);
    end
    @(posedge clk);
    byte_valid  <= 1'b0;
    clk_en      <= 1'b0;
    instr_ready <= 1'b1;
    @(posedge clk);
    #1;
    chk("frozen", instr_valid, 1'b1);
    @(posedge clk);
    clk_en <= 1'b1;
    run(8'h00, 8'h00, 8'h00, 16'h0060, 1);
    chk("after stall", instr_op, cid_pkg::CID_OP_NOP);
  endtask

  // Reset lands on a stalled divide; the decoder must come back clean
  task automatic t_mid_reset();
    @(posedge clk);
    instr_ready <= 1'b0;
    run(8'h84, 8'h00, 8'h00, 16'h0070, 1);
    t_reset();
    run(8'hA5, 8'h00, 8'h00, 16'h0080, 1);
    chk("undef", {instr_len, instr_cycles}, {2'h1, 3'h1});
  endtask

  initial begin
    #100000;
    bad_count++;
    stop_test();
  end

  initial begin
    t_reset();
    t_table();
    t_targets();
    t_operands();
    t_stall();
    t_mid_reset();
    stop_test();
  end
endmodule
